// ==== alarm_mgr_pkg.sv ====
// Purpose: shared constants and types for the controller error/alarm manager
// Assumes: 10 MHz system clock, 16-bit register port
// Notes:   register offsets are word indices on the plain register port
package alarm_mgr_pkg;

  // clock and lamp flash timing
  localparam int unsigned CLK_HZ         = 10_000_000;
  localparam int unsigned FLASH_HALF_MS  = 500;
  localparam int unsigned FLASH_HALF_CYC = (CLK_HZ / 1000) * FLASH_HALF_MS;
  localparam int          FLASH_CW       = 23;

  // widths and depths
  localparam int DATA_W    = 16;
  localparam int ALARM_W   = 8;
  localparam int KIND_W    = 2;
  localparam int ENTRY_W   = KIND_W + DATA_W;
  localparam int AQ_DEPTH  = 4;
  localparam int AQ_CW     = 3;
  localparam int MSG_AW    = 3;
  localparam int MSG_DEPTH = 8;
  localparam int MSG_CW    = 4;
  localparam int REG_AW    = 4;

  // stored message kinds
  localparam logic [KIND_W-1:0] KIND_FATAL    = 2'h0;
  localparam logic [KIND_W-1:0] KIND_NONFATAL = 2'h1;
  localparam logic [KIND_W-1:0] KIND_MESSAGE  = 2'h2;

  // register offsets
  localparam logic [REG_AW-1:0] REG_STATUS    = 4'h0;
  localparam logic [REG_AW-1:0] REG_ALARM     = 4'h1;
  localparam logic [REG_AW-1:0] REG_ALARM_CNT = 4'h2;
  localparam logic [REG_AW-1:0] REG_MSG_CNT   = 4'h3;
  localparam logic [REG_AW-1:0] REG_CTRL      = 4'h4;

  // status field positions
  localparam int ST_FATAL        = 0;
  localparam int ST_NONFATAL     = 1;
  localparam int ST_INIT_SPECIAL = 2;
  localparam int ST_INIT_REMOTE  = 3;
  localparam int ST_STARTED      = 4;
  localparam int ST_VIEWING      = 5;

  // control field positions (write-only command bits)
  localparam int CTRL_CLEAR_FLAGS = 0;

  typedef enum logic [1:0] {
    MODE_PROGRAM = 2'b00,
    MODE_MONITOR = 2'b01,
    MODE_RUN     = 2'b10
  } op_mode_t;

  typedef enum logic [1:0] {
    CON_IDLE  = 2'b00,
    CON_FETCH = 2'b01,
    CON_SHOW  = 2'b10
  } con_state_t;

endpackage

// ==== msg_store_mem.sv ====
// Purpose: small storage for queued error messages, registered read data
// Assumes: one write and one read per cycle, write address never equals a live read
// Notes:   contents are data only and are not cleared by reset
`timescale 1ns/1ps
`default_nettype none
module msg_store_mem (
  // clock and reset
  input  wire logic                                clk,
  input  wire logic                                rst_n,
  // write port
  input  wire logic                                wr_en,
  input  wire logic [alarm_mgr_pkg::MSG_AW-1:0]    wr_addr,
  input  wire logic [alarm_mgr_pkg::ENTRY_W-1:0]   wr_data,
  // read port
  input  wire logic [alarm_mgr_pkg::MSG_AW-1:0]    rd_addr,
  output logic      [alarm_mgr_pkg::ENTRY_W-1:0]   rd_data
);
  import alarm_mgr_pkg::*;

  typedef struct packed {
    logic [MSG_DEPTH-1:0][ENTRY_W-1:0] mem;
    logic [ENTRY_W-1:0]                rdata;
  } mem_state_t;

  mem_state_t s_q;
  mem_state_t s_d;

  always_comb begin
    s_d       = s_q;
    s_d.rdata = s_q.mem[rd_addr];
    if (wr_en) begin
      s_d.mem[wr_addr] = wr_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_q.rdata <= '0;
      s_q.mem   <= s_d.mem;
    end else begin
      s_q <= s_d;
    end
  end

  assign rd_data = s_q.rdata;

endmodule
`default_nettype wire

// ==== error_alarm_manager.sv ====
// Purpose: error classification, alarm/error lamp, halt control, alarm queue and console message store
// Assumes: all inputs synchronous to clk; event inputs are one-cycle pulses
// Notes:   console read/advance are pulses; register reads answer one cycle later
`timescale 1ns/1ps
`default_nettype none
module error_alarm_manager #(
  parameter int unsigned FLASH_HALF_CYC = alarm_mgr_pkg::FLASH_HALF_CYC
) (
  // clock and reset
  input  wire logic                                 clk,
  input  wire logic                                 rst_n,
  // register port
  input  wire logic [alarm_mgr_pkg::REG_AW-1:0]     reg_addr,
  input  wire logic [alarm_mgr_pkg::DATA_W-1:0]     reg_wdata,
  input  wire logic                                 reg_wr,
  input  wire logic                                 reg_rd,
  output logic      [alarm_mgr_pkg::DATA_W-1:0]     reg_rdata,
  // operating mode
  input  wire alarm_mgr_pkg::op_mode_t              op_mode,
  // user program instructions
  input  wire logic                                 nonfatal_alarm_instr,
  input  wire logic                                 fatal_stop_instr,
  input  wire logic [alarm_mgr_pkg::ALARM_W-1:0]    instr_alarm_no,
  input  wire logic                                 message_display_instr,
  input  wire logic [alarm_mgr_pkg::DATA_W-1:0]     message_word,
  // detected system errors
  input  wire logic                                 hw_fatal_err,
  input  wire logic                                 sw_fatal_err,
  input  wire logic                                 nonfatal_err,
  input  wire logic [alarm_mgr_pkg::ALARM_W-1:0]    err_alarm_no,
  // unit start-up status
  input  wire logic                                 special_units_ready,
  input  wire logic                                 remote_powered,
  input  wire logic                                 remote_terminator_ok,
  // programming console
  input  wire logic                                 console_read_req,
  input  wire logic                                 advance_key,
  output logic                                      con_valid,
  output logic      [alarm_mgr_pkg::KIND_W-1:0]     con_kind,
  output logic      [alarm_mgr_pkg::DATA_W-1:0]     con_data,
  output logic                                      con_all_clear,
  output logic                                      con_clear_refused,
  output logic                                      msg_out_valid,
  output logic      [alarm_mgr_pkg::DATA_W-1:0]     msg_out_data,
  // lamps and plant control
  output logic                                      alarm_error_lamp,
  output logic                                      power_lamp,
  output logic                                      run_lamp,
  output logic                                      run_output,
  output logic                                      exec_halt,
  output logic                                      outputs_off,
  output logic                                      init_wait_special,
  output logic                                      init_wait_remote,
  output logic      [alarm_mgr_pkg::ALARM_W-1:0]    system_flag_area
);
  import alarm_mgr_pkg::*;

  typedef struct packed {
    con_state_t                       con;
    logic [MSG_AW-1:0]                wr_ptr;
    logic [MSG_AW-1:0]                rd_ptr;
    logic [MSG_AW-1:0]                view;
    logic [MSG_CW-1:0]                msg_cnt;
    logic [MSG_CW-1:0]                view_off;
    logic [AQ_DEPTH-1:0][ALARM_W-1:0] aq;
    logic [AQ_CW-1:0]                 aq_cnt;
    logic                             fatal;
    logic                             nonfatal;
    logic                             started;
    logic                             flash_phase;
    logic [FLASH_CW-1:0]              flash_cnt;
    logic                             lamp;
    logic                             power;
    logic                             run_lamp;
    logic                             run_out;
    logic                             halt;
    logic                             outs_off;
    logic                             init_special;
    logic                             init_remote;
    logic [ALARM_W-1:0]               alarm_field;
    logic                             con_valid;
    logic [KIND_W-1:0]                con_kind;
    logic [DATA_W-1:0]                con_data;
    logic                             con_all_clear;
    logic                             con_refused;
    logic                             msg_valid;
    logic [DATA_W-1:0]                msg_data;
    logic [DATA_W-1:0]                rdata;
  } state_t;

  localparam logic [FLASH_CW-1:0] FLASH_LAST = FLASH_CW'(FLASH_HALF_CYC - 1);

  state_t                           s_q;
  state_t                           s_d;
  logic [ENTRY_W-1:0]               mem_rdata;
  logic                             push;
  logic                             push_ok;
  logic [ENTRY_W-1:0]               push_entry;
  logic                             pop;
  logic                             clear_all;
  logic                             init_wait;
  logic                             aq_push;
  logic                             aq_pop;
  logic [ALARM_W-1:0]               aq_num;
  logic [AQ_DEPTH-1:0][ALARM_W-1:0] aq_tmp;
  logic [AQ_CW-1:0]                 aq_cnt_tmp;
  logic                             fatal_evt;

  function automatic logic [MSG_AW-1:0] ptr_add(input logic [MSG_AW-1:0] base,
                                                input logic [MSG_CW-1:0] off);
    ptr_add = MSG_AW'(base + off[MSG_AW-1:0]);
  endfunction

  always_comb begin
    s_d               = s_q;
    s_d.con_valid     = 1'b0;
    s_d.con_all_clear = 1'b0;
    s_d.con_refused   = 1'b0;
    s_d.msg_valid     = 1'b0;
    s_d.rdata         = '0;
    pop               = 1'b0;
    clear_all         = 1'b0;
    aq_tmp            = s_q.aq;
    aq_cnt_tmp        = s_q.aq_cnt;

    s_d.init_special = !special_units_ready;
    s_d.init_remote  = !remote_powered || !remote_terminator_ok;
    init_wait        = s_d.init_special || s_d.init_remote;

    fatal_evt = hw_fatal_err || sw_fatal_err || fatal_stop_instr;

    // classify and pick entry to store
    push       = 1'b1;
    push_entry = '0;
    if (fatal_stop_instr) begin
      push_entry = {KIND_FATAL, 8'h00, instr_alarm_no};
    end else if (hw_fatal_err || sw_fatal_err) begin
      push_entry = {KIND_FATAL, 8'h00, err_alarm_no};
    end else if (nonfatal_alarm_instr && instr_alarm_no != 8'h00) begin
      push_entry = {KIND_NONFATAL, 8'h00, instr_alarm_no};
    end else if (nonfatal_err) begin
      push_entry = {KIND_NONFATAL, 8'h00, err_alarm_no};
    end else if (message_display_instr) begin
      push_entry = {KIND_MESSAGE, message_word};
    end else begin
      push = 1'b0;
    end

    // message straight to the programming device
    if (message_display_instr) begin
      s_d.msg_valid = 1'b1;
      s_d.msg_data  = message_word;
    end

    // console viewer
    case (s_q.con)
      CON_IDLE: begin
        if (console_read_req || advance_key) begin
          if (s_q.msg_cnt == '0) begin
            s_d.con_all_clear = 1'b1;
          end else begin
            s_d.view_off = '0;
            s_d.view     = s_q.rd_ptr;
            s_d.con      = CON_FETCH;
          end
        end
      end
      CON_FETCH: begin
        s_d.con_valid = 1'b1;
        s_d.con_kind  = mem_rdata[ENTRY_W-1 -: KIND_W];
        s_d.con_data  = mem_rdata[DATA_W-1:0];
        s_d.con       = CON_SHOW;
      end
      CON_SHOW: begin
        if (console_read_req) begin
          s_d.view_off = '0;
          s_d.view     = s_q.rd_ptr;
          s_d.con      = CON_FETCH;
        end else if (advance_key) begin
          if (op_mode == MODE_PROGRAM) begin
            pop          = 1'b1;
            s_d.rd_ptr   = ptr_add(s_q.view, MSG_CW'(1));
            s_d.view_off = '0;
            s_d.view     = s_d.rd_ptr;
            if (s_q.msg_cnt - MSG_CW'(s_q.view_off) == MSG_CW'(1) && s_q.view_off == '0
                && s_q.msg_cnt == MSG_CW'(1)) begin
              s_d.con_all_clear = 1'b1;
              clear_all         = 1'b1;
              s_d.con           = CON_IDLE;
            end else begin
              s_d.con = CON_FETCH;
            end
          end else begin
            s_d.con_refused = 1'b1;
            if (s_q.view_off + MSG_CW'(1) >= s_q.msg_cnt) begin
              s_d.view_off = '0;
            end else begin
              s_d.view_off = s_q.view_off + MSG_CW'(1);
            end
            s_d.view = ptr_add(s_q.rd_ptr, s_d.view_off);
            s_d.con  = CON_FETCH;
          end
        end
      end
      default: begin
        s_d.con = CON_IDLE;
      end
    endcase

    // only the oldest entry may be cleared; a stepped view clears from the head
    if (pop) begin
      s_d.rd_ptr = ptr_add(s_q.rd_ptr, MSG_CW'(1));
      s_d.view   = s_d.rd_ptr;
      if (s_q.msg_cnt == MSG_CW'(1)) begin
        s_d.con_all_clear = 1'b1;
        clear_all         = 1'b1;
        s_d.con           = CON_IDLE;
      end
    end

    // full store drops the newest entry, never an old one
    push_ok = push && (s_q.msg_cnt != MSG_CW'(MSG_DEPTH) || pop);
    if (push_ok) begin
      s_d.wr_ptr = ptr_add(s_q.wr_ptr, MSG_CW'(1));
    end
    s_d.msg_cnt = s_q.msg_cnt + MSG_CW'(push_ok) - MSG_CW'(pop);

    // alarm number queue, oldest at the head
    aq_pop  = nonfatal_alarm_instr && instr_alarm_no == 8'h00 && s_q.aq_cnt != '0;
    aq_push = 1'b1;
    aq_num  = err_alarm_no;
    if (fatal_stop_instr || (nonfatal_alarm_instr && instr_alarm_no != 8'h00)) begin
      aq_num = instr_alarm_no;
    end else if (!((hw_fatal_err || sw_fatal_err || nonfatal_err) && err_alarm_no != 8'h00)) begin
      aq_push = 1'b0;
    end
    // zero number removes the current alarm
    if (aq_pop) begin
      for (int i = 0; i < AQ_DEPTH - 1; i++) begin
        aq_tmp[i] = aq_tmp[i+1];
      end
      aq_tmp[AQ_DEPTH-1] = '0;
      aq_cnt_tmp         = aq_cnt_tmp - AQ_CW'(1);
    end
    // nonzero numbers join the alarm queue while it holds fewer than 4
    if (aq_push && aq_cnt_tmp < AQ_CW'(AQ_DEPTH)) begin
      aq_tmp[aq_cnt_tmp[AQ_CW-2:0]] = aq_num;
      aq_cnt_tmp                    = aq_cnt_tmp + AQ_CW'(1);
    end
    s_d.aq          = aq_tmp;
    s_d.aq_cnt      = aq_cnt_tmp;
    s_d.alarm_field = (aq_cnt_tmp != '0) ? aq_tmp[0] : '0;

    // register writes; clearing only honoured in program mode
    if (reg_wr && reg_addr == REG_CTRL && reg_wdata[CTRL_CLEAR_FLAGS]) begin
      if (op_mode == MODE_PROGRAM) begin
        clear_all = 1'b1;
      end else begin
        s_d.con_refused = 1'b1;
      end
    end

    // granted clear drops both flags
    if (clear_all) begin
      s_d.fatal    = 1'b0;
      s_d.nonfatal = 1'b0;
    end
    // set wins over clear
    if (fatal_evt) begin
      s_d.fatal = 1'b1;
    end
    if (nonfatal_err || (nonfatal_alarm_instr && instr_alarm_no != 8'h00)) begin
      s_d.nonfatal = 1'b1;
    end

    if (!s_q.started) begin
      s_d.started = !init_wait && op_mode != MODE_PROGRAM && !s_d.fatal;
    end else if (op_mode == MODE_PROGRAM) begin
      s_d.started = 1'b0;
    end

    s_d.halt     = s_d.fatal;
    s_d.outs_off = s_d.fatal;
    s_d.power    = 1'b1;
    s_d.run_lamp = s_d.started && !s_d.fatal;
    s_d.run_out  = s_d.started && !s_d.fatal;

    // flash timebase
    if (s_q.flash_cnt >= FLASH_LAST) begin
      s_d.flash_cnt   = '0;
      s_d.flash_phase = !s_q.flash_phase;
    end else begin
      s_d.flash_cnt = s_q.flash_cnt + FLASH_CW'(1);
    end
    if (s_d.fatal) begin
      s_d.lamp = 1'b1;
    end else if (s_d.nonfatal) begin
      s_d.lamp = s_d.flash_phase;
    end else begin
      s_d.lamp = 1'b0;
    end

    // register reads, unmapped reads as zero
    if (reg_rd) begin
      case (reg_addr)
        REG_STATUS: begin
          s_d.rdata[ST_FATAL]        = s_q.fatal;
          s_d.rdata[ST_NONFATAL]     = s_q.nonfatal;
          s_d.rdata[ST_INIT_SPECIAL] = s_q.init_special;
          s_d.rdata[ST_INIT_REMOTE]  = s_q.init_remote;
          s_d.rdata[ST_STARTED]      = s_q.started;
          s_d.rdata[ST_VIEWING]      = s_q.con != CON_IDLE;
        end
        REG_ALARM:     s_d.rdata = {8'h00, s_q.alarm_field};
        REG_ALARM_CNT: s_d.rdata = DATA_W'(s_q.aq_cnt);
        REG_MSG_CNT:   s_d.rdata = DATA_W'(s_q.msg_cnt);
        default:       s_d.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  msg_store_mem u_store (
    .clk     (clk),
    .rst_n   (rst_n),
    .wr_en   (push_ok),
    .wr_addr (s_q.wr_ptr),
    .wr_data (push_entry),
    .rd_addr (s_d.view),
    .rd_data (mem_rdata)
  );

  assign reg_rdata         = s_q.rdata;
  assign con_valid         = s_q.con_valid;
  assign con_kind          = s_q.con_kind;
  assign con_data          = s_q.con_data;
  assign con_all_clear     = s_q.con_all_clear;
  assign con_clear_refused = s_q.con_refused;
  assign msg_out_valid     = s_q.msg_valid;
  assign msg_out_data      = s_q.msg_data;
  assign alarm_error_lamp  = s_q.lamp;
  assign power_lamp        = s_q.power;
  assign run_lamp          = s_q.run_lamp;
  assign run_output        = s_q.run_out;
  assign exec_halt         = s_q.halt;
  assign outputs_off       = s_q.outs_off;
  assign init_wait_special = s_q.init_special;
  assign init_wait_remote  = s_q.init_remote;
  assign system_flag_area  = s_q.alarm_field;

endmodule
`default_nettype wire

// ==== error_alarm_manager_asserts.sv ====
// Purpose: port-level checks for the error/alarm manager
// Assumes: one clock, synchronous active-low reset
// Notes: bound into every manager instance
`timescale 1ns/1ps
`default_nettype none
module error_alarm_manager_asserts (
  // clock and reset
  input wire logic                               clk,
  input wire logic                               rst_n,
  // causes
  input wire alarm_mgr_pkg::op_mode_t            op_mode,
  input wire logic                               nonfatal_alarm_instr,
  input wire logic                               fatal_stop_instr,
  input wire logic [alarm_mgr_pkg::ALARM_W-1:0]  instr_alarm_no,
  input wire logic                               message_display_instr,
  input wire logic [alarm_mgr_pkg::DATA_W-1:0]   message_word,
  input wire logic                               hw_fatal_err,
  input wire logic                               sw_fatal_err,
  input wire logic                               special_units_ready,
  input wire logic                               remote_powered,
  input wire logic                               remote_terminator_ok,
  // effects
  input wire logic                               con_clear_refused,
  input wire logic                               msg_out_valid,
  input wire logic [alarm_mgr_pkg::DATA_W-1:0]   msg_out_data,
  input wire logic                               alarm_error_lamp,
  input wire logic                               power_lamp,
  input wire logic                               run_lamp,
  input wire logic                               run_output,
  input wire logic                               exec_halt,
  input wire logic                               outputs_off,
  input wire logic                               init_wait_special,
  input wire logic                               init_wait_remote,
  input wire logic [alarm_mgr_pkg::ALARM_W-1:0]  system_flag_area
);
  import alarm_mgr_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // same-cycle fatal events halt even with an alarm, so the alarm checks exclude them
  wire logic quiet = !fatal_stop_instr && !hw_fatal_err && !sw_fatal_err;

  property p_stop_halts; fatal_stop_instr |=> exec_halt && outputs_off && alarm_error_lamp; endproperty
  a_stop_halts: assert property (p_stop_halts) else $error("stop did not halt");
  property p_fault_halts; hw_fatal_err || sw_fatal_err |=> exec_halt && outputs_off; endproperty
  a_fault_halts: assert property (p_fault_halts) else $error("fault did not halt");
  property p_halt_dark; exec_halt |-> !run_output && !run_lamp; endproperty
  a_halt_dark: assert property (p_halt_dark) else $error("running while halted");
  property p_steady; $rose(exec_halt) |-> alarm_error_lamp [*6]; endproperty
  a_steady: assert property (p_steady) else $error("lamp not steady on fatal");
  property p_alarm_field;
    nonfatal_alarm_instr && instr_alarm_no != 8'h00 && system_flag_area == 8'h00 && quiet
      |=> system_flag_area == $past(instr_alarm_no);
  endproperty
  a_alarm_field: assert property (p_alarm_field) else $error("alarm field not loaded");
  property p_alarm_runs; nonfatal_alarm_instr && quiet && !exec_halt |=> !exec_halt && !outputs_off; endproperty
  a_alarm_runs: assert property (p_alarm_runs) else $error("alarm halted");
  property p_msg_out; message_display_instr |=> msg_out_valid && msg_out_data == $past(message_word); endproperty
  a_msg_out: assert property (p_msg_out) else $error("message not sent");
  property p_refused; con_clear_refused |-> $past(op_mode) != MODE_PROGRAM; endproperty
  a_refused: assert property (p_refused) else $error("refusal in program mode");
  property p_init_wait;
    1'b1 |=> init_wait_special == !$past(special_units_ready)
      && init_wait_remote == !($past(remote_powered) && $past(remote_terminator_ok));
  endproperty
  a_init_wait: assert property (p_init_wait) else $error("wait flags wrong");
  property p_power; $past(rst_n) |-> power_lamp; endproperty
  a_power: assert property (p_power) else $error("power lamp dark");
endmodule
bind error_alarm_manager error_alarm_manager_asserts u_asserts (.*);
`default_nettype wire

// ==== console_model.sv ====
// Purpose: programming console stand-in, reads and clears stored messages
// Assumes: one press outstanding at a time
// Notes: gap models a slow operator between presses
`timescale 1ns/1ps
`default_nettype none
module console_model (
  // clock
  input  wire logic                             clk,
  // keys
  output var logic                              console_read_req,
  output var logic                              advance_key,
  // answers
  input  wire logic                             con_valid,
  input  wire logic [alarm_mgr_pkg::KIND_W-1:0] con_kind,
  input  wire logic [alarm_mgr_pkg::DATA_W-1:0] con_data,
  input  wire logic                             con_all_clear,
  input  wire logic                             con_clear_refused
);
  import alarm_mgr_pkg::*;
  logic [KIND_W-1:0] kind;
  logic [DATA_W-1:0] data;
  logic              all_clear;
  logic              refused;
  initial begin
    console_read_req = 1'b0;
    advance_key = 1'b0;
  end
  // operator paces presses, waits for each answer
  task automatic press(input logic adv, input int gap);
    int n;
    repeat (gap) @(posedge clk);
    @(posedge clk);
    console_read_req <= !adv;
    advance_key <= adv;
    refused = 1'b0;
    n = 0;
    @(posedge clk);
    console_read_req <= 1'b0;
    advance_key <= 1'b0;
    do begin
      @(negedge clk);
      refused |= con_clear_refused;
      n++;
    end while (!con_valid && !con_all_clear && n < 8);
    kind = con_kind;
    data = con_data;
    all_clear = con_all_clear;
  endtask
endmodule
`default_nettype wire

// ==== tb_error_alarm_manager.sv ====
// Purpose: directed bench for the error/alarm manager
// Assumes: flash half period shortened to 4 cycles
// Notes: console side driven through console_model
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b, m) begin total_checks++; if ((a) !== (b)) begin err_total++; \
  $display("CHECK FAILED t=%0t %s", $time, m); end end
module tb_error_alarm_manager;
  import alarm_mgr_pkg::*;
  logic                clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [REG_AW-1:0]   reg_addr = 4'h0;
  logic [DATA_W-1:0]   reg_wdata = 16'h0000, reg_rdata, rdv, message_word = 16'h0000, msg_out_data, con_data;
  op_mode_t            op_mode = MODE_PROGRAM;
  logic                nonfatal_alarm_instr = 1'b0, fatal_stop_instr = 1'b0, message_display_instr = 1'b0;
  logic                hw_fatal_err = 1'b0, sw_fatal_err = 1'b0, nonfatal_err = 1'b0;
  logic [ALARM_W-1:0]  instr_alarm_no = 8'h00, err_alarm_no = 8'h00, system_flag_area;
  logic                special_units_ready = 1'b1, remote_powered = 1'b1, remote_terminator_ok = 1'b1;
  logic                console_read_req, advance_key, con_valid, con_all_clear, con_clear_refused;
  logic [KIND_W-1:0]   con_kind;
  logic                msg_out_valid, alarm_error_lamp, power_lamp, run_lamp, run_output;
  logic                exec_halt, outputs_off, init_wait_special, init_wait_remote, lamp_s;
  logic [KIND_W-1:0]   kinds [4] = '{KIND_NONFATAL, KIND_NONFATAL, KIND_MESSAGE, KIND_NONFATAL};
  int                  err_total = 0, total_checks = 0;

  error_alarm_manager #(.FLASH_HALF_CYC(4)) uut (.*);
  console_model con (.*);

  always #50 clk = ~clk;

  task automatic wr(input logic [REG_AW-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [REG_AW-1:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    rdv = reg_rdata;
  endtask
  // s: 0 alarm, 1 stop, 2 message, 3 hardware fault, 4 software fault, 5 nonfatal error
  task automatic ev(input int s, input logic [ALARM_W-1:0] n);
    @(posedge clk);
    instr_alarm_no <= n;
    err_alarm_no <= n;
    message_word <= {n, ~n};
    {nonfatal_alarm_instr, fatal_stop_instr, message_display_instr,
     hw_fatal_err, sw_fatal_err, nonfatal_err} <= 6'h20 >> s;
    @(posedge clk);
    {nonfatal_alarm_instr, fatal_stop_instr, message_display_instr, hw_fatal_err, sw_fatal_err, nonfatal_err} <= 6'h00;
    @(negedge clk);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // whole run is under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk);
    err_total++;
    give_verdict();
  end

  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(negedge clk);
    `CHK(power_lamp, 1'b1, "power lamp")
    @(posedge clk);
    special_units_ready <= 1'b0;
    op_mode <= MODE_RUN;
    rd(REG_STATUS);
    `CHK(rdv[ST_INIT_SPECIAL], 1'b1, "special wait")
    `CHK(run_output, 1'b0, "run output while waiting")
    @(posedge clk);
    special_units_ready <= 1'b1;
    remote_terminator_ok <= 1'b0;
    repeat (3) @(negedge clk);
    `CHK(init_wait_remote, 1'b1, "terminator wait")
    @(posedge clk);
    remote_terminator_ok <= 1'b1;
    remote_powered <= 1'b0;
    repeat (3) @(negedge clk);
    `CHK(init_wait_remote, 1'b1, "remote power wait")
    `CHK(run_lamp, 1'b0, "run lamp while waiting")
    @(posedge clk);
    remote_powered <= 1'b1;
    $display("init test done");
    ev(0, 8'h12);
    `CHK(system_flag_area, 8'h12, "alarm field")
    ev(5, 8'h34);
    `CHK(system_flag_area, 8'h12, "oldest stays")
    rd(REG_ALARM_CNT);
    `CHK(rdv, 16'h0002, "alarm count")
    `CHK(exec_halt, 1'b0, "alarm halted")
    `CHK(run_output, 1'b1, "run output")
    `CHK(run_lamp, 1'b1, "run lamp")
    lamp_s = alarm_error_lamp;
    repeat (4) @(negedge clk);
    `CHK(alarm_error_lamp, ~lamp_s, "lamp flash")
    repeat (4) @(negedge clk);
    `CHK(alarm_error_lamp, lamp_s, "lamp flash back")
    ev(0, 8'h00);
    `CHK(system_flag_area, 8'h34, "next alarm")
    ev(0, 8'h00);
    `CHK(system_flag_area, 8'h00, "queue empty")
    ev(0, 8'h00);
    `CHK(system_flag_area, 8'h00, "pop on empty")
    ev(2, 8'h5a);
    `CHK(msg_out_data, 16'h5aa5, "message word")
    rd(REG_MSG_CNT);
    `CHK(rdv, 16'h0003, "stored count")
    $display("alarm test done");
    for (int i = 0; i < 4; i++) begin
      con.press(i > 0, i);
      `CHK(con.kind, kinds[i], "viewed kind")
      `CHK(con.refused, i > 0, "clear refused")
    end
    `CHK(con.data, 16'h0012, "wrapped view")
    rd(REG_MSG_CNT);
    `CHK(rdv, 16'h0003, "nothing cleared")
    @(posedge clk);
    op_mode <= MODE_PROGRAM;
    con.press(1'b1, 0);
    `CHK(con.kind, KIND_NONFATAL, "head after clear")
    rd(REG_MSG_CNT);
    `CHK(rdv, 16'h0002, "one removed")
    con.press(1'b1, 2);
    `CHK(con.data, 16'h5aa5, "message head")
    con.press(1'b1, 0);
    `CHK(con.all_clear, 1'b1, "all clear")
    rd(REG_STATUS);
    `CHK(rdv[1:0], 2'b00, "flags cleared")
    $display("console test done");
    @(posedge clk);
    op_mode <= MODE_MONITOR;
    repeat (3) @(negedge clk);
    `CHK(run_output, 1'b1, "running again")
    ev(1, 8'h77);
    `CHK(outputs_off, 1'b1, "outputs off")
    `CHK(system_flag_area, 8'h77, "stop number")
    repeat (5) @(negedge clk);
    `CHK(alarm_error_lamp, 1'b1, "lamp steady")
    `CHK(run_output, 1'b0, "run output off")
    ev(3, 8'h55);
    ev(4, 8'h00);
    wr(REG_CTRL, 16'h0001);
    rd(REG_ALARM_CNT);
    `CHK(rdv, 16'h0002, "fatal numbers queued")
    rd(REG_STATUS);
    `CHK(rdv[ST_FATAL], 1'b1, "fatal class")
    @(posedge clk);
    op_mode <= MODE_PROGRAM;
    wr(REG_CTRL, 16'h0001);
    rd(REG_STATUS);
    `CHK(rdv[1:0], 2'b00, "clear in program")
    rd(REG_CTRL);
    `CHK(rdv, 16'h0000, "control reads zero")
    rd(4'hf);
    `CHK(rdv, 16'h0000, "unmapped read")
    $display("fatal test done");
    give_verdict();
  end
endmodule
`default_nettype wire
